// *** hw/erb_map.svh ***
// register offsets, field positions, reset values for the embedded ram block
// ===========================================================================
`ifndef ERB_MAP_SVH
`define ERB_MAP_SVH
// ===========================================================================
// apb register byte offsets
`define ERB_OFS_CFG   12'h000
`define ERB_OFS_LDADR 12'h004
`define ERB_OFS_LDDAT 12'h008
`define ERB_OFS_STAT  12'h00C
// ===========================================================================
// config field positions (lsb) and reset value
`define ERB_CFG_BANK_ID 0
`define ERB_CFG_BANK_EN 3
`define ERB_CFG_OUT_SRC 4
`define ERB_CFG_IN_SRC  6
`define ERB_CFG_WE_GLB  8
`define ERB_CFG_REG_ADR 9
`define ERB_CFG_REG_OUT 10
`define ERB_CFG_REG_DIN 11
`define ERB_CFG_ORG     12
`define ERB_CFG_MODE    14
`define ERB_CFG_RST     17'h0_0000
// ===========================================================================
// storage size
`define ERB_ADR_MAX     11'h7FF
`define ERB_DEPTH_MAX   12'h800
`endif

// *** hw/erb_pkg.sv ***
// types shared by the embedded ram block modules
package erb_pkg;
  typedef enum logic [2:0] {ERB_RAM, ERB_ROM, ERB_DPRAM, ERB_FIFO,
                            ERB_LUT} erb_mode_t;
  typedef enum logic [1:0] {ERB_X8, ERB_X4, ERB_X2, ERB_X1} erb_org_t;
  typedef enum logic [1:0] {ERB_SRC_GLB, ERB_SRC_PIN,
                            ERB_SRC_LOC} erb_src_t;
  typedef struct packed {
    erb_mode_t  mode;
    erb_org_t   org;
    logic       reg_din;
    logic       reg_out;
    logic       reg_adr;
    logic       we_glb;
    erb_src_t   in_src;
    erb_src_t   out_src;
    logic       bank_en;
    logic [2:0] bank_id;
  } erb_cfg_t;
  typedef struct packed {
    logic [2047:0] bits;
  } erb_mem_st_t;
  typedef struct packed {
    erb_cfg_t    cfg;
    logic [7:0]  ld_adr;
    logic [7:0]  din_q;
    logic [10:0] adr_q;
    logic        we_q;
    logic [10:0] wr_ptr;
    logic [10:0] rd_ptr;
    logic [11:0] count;
    logic [7:0]  dout;
    logic        full;
    logic        empty;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } erb_top_st_t;
endpackage : erb_pkg

// *** hw/erb_src_sel.sv ***
// clock-enable source selector for one side of the ram block
`timescale 1ns/10ps
module erb_src_sel (
  input  wire erb_pkg::erb_src_t src,    // chosen source
  input  wire logic              en_glb, // global signal
  input  wire logic              en_pin, // dedicated clock pin
  input  wire logic              en_loc, // local interconnect
  output logic                   en      // selected enable
);
  // =========================================================================
  // source mux, unused code gives no edges at all
  always_comb begin
    unique case (src)
      erb_pkg::ERB_SRC_GLB: en = en_glb;
      erb_pkg::ERB_SRC_PIN: en = en_pin;
      erb_pkg::ERB_SRC_LOC: en = en_loc;
      default:              en = 1'b0;
    endcase
  end
endmodule : erb_src_sel

// *** hw/erb_mem_array.sv ***
// 2,048-bit flip-flop storage with one write and two read ports
`timescale 1ns/10ps
module erb_mem_array (
  input  wire logic        clk_sys,   // system clock
  input  wire logic        arst_n,    // async reset, active low
  input  wire logic        wr_en,     // write strobe
  input  wire logic [10:0] wr_base,   // first bit index of the word
  input  wire logic [7:0]  wr_mask,   // bits of the word to write
  input  wire logic [7:0]  wr_data,   // write data, low bits used
  input  wire logic [10:0] rd_base_a, // read port a bit index
  input  wire logic [10:0] rd_base_b, // read port b bit index
  output logic      [7:0]  rd_data_a, // read port a data, unmasked
  output logic      [7:0]  rd_data_b  // read port b data, unmasked
);
  erb_pkg::erb_mem_st_t st_ff;
  erb_pkg::erb_mem_st_t nxt_st;

  // =========================================================================
  // bit-wise write, so every organisation shares one array
  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      for (int i = 0; i < 8; i++) begin
        if (wr_mask[i]) begin
          nxt_st.bits[wr_base + 11'(i)] = wr_data[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =========================================================================
  // read ports; index wraps, caller masks bits beyond the word width
  for (genvar g = 0; g < 8; g++) begin : g_rd
    assign rd_data_a[g] = st_ff.bits[rd_base_a + 11'(g)];
    assign rd_data_b[g] = st_ff.bits[rd_base_b + 11'(g)];
  end
endmodule : erb_mem_array

// *** hw/erb_top.sv ***
// embedded ram block: configurable ram, rom, dual-port, fifo, lookup table
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "erb_map.svh"
module erb_top (
  input  wire logic        clk_sys,     // system clock, 20 MHz
  input  wire logic        arst_n,      // async reset, active low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction
  input  wire logic [11:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error
  input  wire logic [10:0] ram_addr,    // user address
  input  wire logic [10:0] ram_rd_addr, // dual-port read address
  input  wire logic [7:0]  ram_din,     // user write data
  input  wire logic        we_local,    // write request, local path
  input  wire logic        we_global,   // write request, global path
  input  wire logic        fifo_pop,    // fifo read request
  input  wire logic [2:0]  blk_sel,     // depth cascade block select
  input  wire logic        in_en_glb,   // input clock edge, global
  input  wire logic        in_en_pin,   // input clock edge, clock pin
  input  wire logic        in_en_loc,   // input clock edge, local
  input  wire logic        out_en_glb,  // output clock edge, global
  input  wire logic        out_en_pin,  // output clock edge, clock pin
  input  wire logic        out_en_loc,  // output clock edge, local
  output logic      [7:0]  ram_dout,    // read data
  output logic             fifo_full,   // fifo full
  output logic             fifo_empty   // fifo empty
);
  erb_pkg::erb_top_st_t st_ff;
  erb_pkg::erb_top_st_t nxt_st;
  erb_pkg::erb_cfg_t    cfg;
  logic                 in_en;
  logic                 out_en;
  logic                 we_raw;
  logic [7:0]           eff_din;
  logic [10:0]          eff_adr;
  logic                 eff_we;
  logic                 blk_hit;
  logic [7:0]           wmask;
  logic [3:0]           sh;
  logic [10:0]          dmask;
  logic [11:0]          depth;
  logic                 apb_acc;
  logic                 apb_done;
  logic                 apb_ld;
  logic                 user_wr;
  logic                 push;
  logic                 pop;
  logic                 mem_wr;
  logic [10:0]          mem_wbase;
  logic [7:0]           mem_wmask;
  logic [7:0]           mem_wdata;
  logic [10:0]          rd_adr;
  logic [7:0]           rd_a;
  logic [7:0]           rd_b;
  logic [7:0]           rd_raw;

  // =========================================================================
  // helpers
  // word width mask of an organisation
  function automatic logic [7:0] org_mask(input erb_pkg::erb_org_t o);
    return 8'hFF >> (4'h8 - (4'h8 >> o));
  endfunction : org_mask

  // config word to fields
  function automatic erb_pkg::erb_cfg_t cfg_decode(input logic [31:0] d);
    erb_pkg::erb_cfg_t c;
    c.mode    = erb_pkg::erb_mode_t'(d[`ERB_CFG_MODE +: 3]);
    c.org     = erb_pkg::erb_org_t'(d[`ERB_CFG_ORG +: 2]);
    c.reg_din = d[`ERB_CFG_REG_DIN];
    c.reg_out = d[`ERB_CFG_REG_OUT];
    c.reg_adr = d[`ERB_CFG_REG_ADR];
    c.we_glb  = d[`ERB_CFG_WE_GLB];
    c.in_src  = erb_pkg::erb_src_t'(d[`ERB_CFG_IN_SRC +: 2]);
    c.out_src = erb_pkg::erb_src_t'(d[`ERB_CFG_OUT_SRC +: 2]);
    c.bank_en = d[`ERB_CFG_BANK_EN];
    c.bank_id = d[`ERB_CFG_BANK_ID +: 3];
    return c;
  endfunction : cfg_decode

  assign cfg = st_ff.cfg;

  // =========================================================================
  // clock edge sources; one system clock, each side gets an enable
  erb_src_sel u_in_sel (
    .src    (cfg.in_src),
    .en_glb (in_en_glb),
    .en_pin (in_en_pin),
    .en_loc (in_en_loc),
    .en     (in_en)
  );

  erb_src_sel u_out_sel (
    .src    (cfg.out_src),
    .en_glb (out_en_glb),
    .en_pin (out_en_pin),
    .en_loc (out_en_loc),
    .en     (out_en)
  );

  // =========================================================================
  // input side: optional registers, write request and address decode
  always_comb begin
    we_raw  = cfg.we_glb ? we_global : we_local;
    eff_din = cfg.reg_din ? st_ff.din_q : ram_din;
    eff_adr = cfg.reg_adr ? st_ff.adr_q : ram_addr;
    eff_we  = cfg.reg_adr ? st_ff.we_q : we_raw;
    // other blocks of a depth cascade own this address
    blk_hit = !cfg.bank_en || (blk_sel == cfg.bank_id);
    wmask   = org_mask(cfg.org);
    sh      = 4'(3 - cfg.org);
    dmask   = `ERB_ADR_MAX >> sh;
    depth   = `ERB_DEPTH_MAX >> sh;
  end

  // =========================================================================
  // write scheduling; the pulse is made here, users only give a request
  always_comb begin
    apb_acc  = psel && penable;
    apb_done = apb_acc && st_ff.pready;
    apb_ld   = apb_done && pwrite && (paddr == `ERB_OFS_LDDAT);
    user_wr  = in_en && eff_we && blk_hit &&
               (cfg.mode == erb_pkg::ERB_RAM ||
                cfg.mode == erb_pkg::ERB_DPRAM);
    push     = in_en && eff_we && blk_hit && !st_ff.full &&
               (cfg.mode == erb_pkg::ERB_FIFO);
    pop      = out_en && fifo_pop && blk_hit && !st_ff.empty &&
               (cfg.mode == erb_pkg::ERB_FIFO);
    // table load beats a user write in the same cycle
    mem_wr    = apb_ld || user_wr || push;
    mem_wmask = apb_ld ? 8'hFF : wmask;
    mem_wdata = apb_ld ? pwdata[7:0] : eff_din;
    if (apb_ld) begin
      mem_wbase = {st_ff.ld_adr, 3'h0};
    end else if (push) begin
      mem_wbase = 11'(st_ff.wr_ptr << sh);
    end else begin
      mem_wbase = 11'((eff_adr & dmask) << sh);
    end
  end

  // =========================================================================
  // read address by mode; dual port reads on its own address
  always_comb begin
    unique case (cfg.mode)
      erb_pkg::ERB_DPRAM: rd_adr = ram_rd_addr & dmask;
      erb_pkg::ERB_FIFO:  rd_adr = st_ff.rd_ptr;
      default:            rd_adr = eff_adr & dmask;
    endcase
    rd_raw = blk_hit ? (rd_a & wmask) : 8'h00;
  end

  erb_mem_array u_mem (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .wr_en     (mem_wr),
    .wr_base   (mem_wbase),
    .wr_mask   (mem_wmask),
    .wr_data   (mem_wdata),
    .rd_base_a (11'(rd_adr << sh)),
    .rd_base_b ({st_ff.ld_adr, 3'h0}),
    .rd_data_a (rd_a),
    .rd_data_b (rd_b)
  );

  // =========================================================================
  // next state: pipeline, fifo pointers, apb slave
  always_comb begin
    nxt_st = st_ff;
    // input-side registers capture on the input clock edge
    if (in_en) begin
      nxt_st.din_q = ram_din;
      nxt_st.adr_q = ram_addr;
      nxt_st.we_q  = we_raw;
    end
    // with reg_out set the output register moves only on the output edge, else every cycle
    if (!cfg.reg_out || out_en) begin
      nxt_st.dout = rd_raw;
    end
    // fifo pointers wrap at the depth of the organisation
    if (push) begin
      nxt_st.wr_ptr = (st_ff.wr_ptr + 11'h001) & dmask;
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr + 11'h001) & dmask;
    end
    nxt_st.count = st_ff.count + 12'(push) - 12'(pop);
    // apb: answer one cycle into the access phase
    nxt_st.pready  = apb_acc && !st_ff.pready;
    nxt_st.pslverr = 1'b0;
    if (apb_acc && !st_ff.pready) begin
      nxt_st.pslverr = !(paddr == `ERB_OFS_CFG || paddr == `ERB_OFS_LDADR ||
                         paddr == `ERB_OFS_LDDAT || paddr == `ERB_OFS_STAT);
      unique case (paddr)
        `ERB_OFS_CFG:   nxt_st.prdata = 32'(cfg);
        `ERB_OFS_LDADR: nxt_st.prdata = 32'(st_ff.ld_adr);
        `ERB_OFS_LDDAT: nxt_st.prdata = 32'(rd_b);
        `ERB_OFS_STAT:  nxt_st.prdata = {18'h0_0000, st_ff.full,
                                          st_ff.empty, st_ff.count};
        default:        nxt_st.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_done && pwrite) begin
      unique case (paddr)
        `ERB_OFS_CFG: begin
          nxt_st.cfg    = cfg_decode(pwdata);
          // a new shape empties the fifo
          nxt_st.wr_ptr = 11'h000;
          nxt_st.rd_ptr = 11'h000;
          nxt_st.count  = 12'h000;
        end
        `ERB_OFS_LDADR: nxt_st.ld_adr = pwdata[7:0];
        `ERB_OFS_LDDAT: nxt_st.ld_adr = st_ff.ld_adr + 8'h01;
        default: ;
      endcase
    end
    nxt_st.full  = nxt_st.count == depth;
    nxt_st.empty = nxt_st.count == 12'h000;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff       <= '0;
      st_ff.cfg   <= `ERB_CFG_RST;
      st_ff.empty <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =========================================================================
  // outputs straight from state
  assign prdata     = st_ff.prdata;
  assign pready     = st_ff.pready;
  assign pslverr    = st_ff.pslverr;
  assign ram_dout   = st_ff.dout;
  assign fifo_full  = st_ff.full;
  assign fifo_empty = st_ff.empty;

  // =========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_out_edge;
    cfg.reg_out && out_en;
  endsequence
  sequence s_out_idle;
    cfg.reg_out && !out_en && !apb_done;
  endsequence

  a_rom_no_write: assert property (
    (cfg.mode == erb_pkg::ERB_ROM || cfg.mode == erb_pkg::ERB_LUT) &&
    !apb_ld |-> !mem_wr)
    else $error("write reached a read-only table");
  a_write_self_timed: assert property (
    mem_wr && !apb_ld |-> in_en && eff_we)
    else $error("write pulse without input clock edge and request");
  a_din_reg_hold: assert property (
    cfg.reg_din && !in_en ##1 !apb_done |-> $stable(st_ff.din_q))
    else $error("data input register moved without input edge");
  a_out_reg_hold: assert property (
    s_out_idle |=> $stable(ram_dout))
    else $error("output register moved without output edge");
  a_out_reg_load: assert property (
    s_out_edge |=> ram_dout == $past(rd_raw))
    else $error("output register missed read data");
  a_out_follow: assert property (
    !cfg.reg_out |=> ram_dout == $past(rd_raw))
    else $error("unregistered output lags the address");
  a_in_src_pin: assert property (
    cfg.in_src == erb_pkg::ERB_SRC_PIN |-> in_en == in_en_pin)
    else $error("input edge not taken from clock pin");
  a_out_src_loc: assert property (
    cfg.out_src == erb_pkg::ERB_SRC_LOC |-> out_en == out_en_loc)
    else $error("output edge not taken from local path");
  a_we_global: assert property (
    cfg.we_glb && !cfg.reg_adr && cfg.mode == erb_pkg::ERB_RAM &&
    in_en && blk_hit && we_global |-> mem_wr)
    else $error("global write enable ignored");
  a_bank_quiet: assert property (
    cfg.bank_en && blk_sel != cfg.bank_id |-> !user_wr && !push &&
    rd_raw == 8'h00)
    else $error("unselected cascade block active");
  a_fifo_refuse: assert property (
    cfg.mode == erb_pkg::ERB_FIFO && st_ff.full && !pop && !apb_done |=>
    st_ff.full && $stable(st_ff.wr_ptr))
    else $error("full fifo took a push");
  a_org_width: assert property (
    user_wr && !apb_ld |-> $countones(mem_wmask) == (8 >> cfg.org))
    else $error("write width differs from organisation");

  // registered request: captured on one input edge, written on the next
  sequence s_wr_capture;
    cfg.reg_adr && cfg.mode == erb_pkg::ERB_RAM && in_en && we_raw &&
    blk_hit && !apb_done;
  endsequence
  sequence s_wr_commit;
    in_en && blk_hit && !apb_ld;
  endsequence
  a_adr_reg_write: assert property (
    s_wr_capture ##1 s_wr_commit |-> mem_wr)
    else $error("registered write request lost");
  a_adr_reg_hold: assert property (
    cfg.reg_adr && !in_en |=> $stable(st_ff.adr_q) && $stable(st_ff.we_q))
    else $error("address register moved without input edge");
  a_din_reg_use: assert property (
    user_wr && cfg.reg_din && !apb_ld |-> mem_wdata == st_ff.din_q)
    else $error("write took live data despite data register");
  // an empty fifo must not move its read side
  a_fifo_idle: assert property (
    st_ff.empty && !push && !apb_done |=> st_ff.empty && $stable(st_ff.rd_ptr))
    else $error("empty fifo moved its read pointer");
  a_fifo_bound: assert property (
    st_ff.count <= depth)
    else $error("fifo count beyond depth");
  a_dp_addr: assert property (
    cfg.mode == erb_pkg::ERB_DPRAM |-> rd_adr == (ram_rd_addr & dmask))
    else $error("dual port not read on its own address");
  // configuration, unselected cascade output and table load
  a_cfg_clear: assert property (
    apb_done && pwrite && paddr == `ERB_OFS_CFG |=>
    st_ff.count == 12'h000 && st_ff.empty)
    else $error("new shape left fifo contents");
  a_bank_out_zero: assert property (
    cfg.bank_en && blk_sel != cfg.bank_id && !cfg.reg_out |=>
    ram_dout == 8'h00)
    else $error("unselected cascade block drove data");
  a_load_step: assert property (
    apb_ld |=> st_ff.ld_adr == $past(st_ff.ld_adr) + 8'h01)
    else $error("table load index did not advance");
  a_ld_wins: assert property (
    apb_ld |-> mem_wr && mem_wmask == 8'hFF && mem_wdata == pwdata[7:0])
    else $error("table load byte not written whole");
  // sources with no edges
  a_in_src_none: assert property (
    cfg.in_src == erb_pkg::erb_src_t'(2'h3) |-> !in_en)
    else $error("input edge from unused source code");
  a_out_src_none: assert property (
    cfg.out_src == erb_pkg::erb_src_t'(2'h3) |-> !out_en)
    else $error("output edge from unused source code");
endmodule : erb_top

// *** sim/erb_user_model.sv ***
// user logic cell model driving the fabric side of the ram block
`timescale 1ns/10ps
module erb_user_model (
  input  wire logic        clk_sys, // system clock
  output logic      [10:0] addr,    // user address
  output logic      [10:0] rd_addr, // second read address
  output logic      [7:0]  din,     // write data
  output logic             we_loc,  // write request, local path
  output logic             we_glb,  // write request, global path
  output logic             pop,     // fifo read request
  output logic      [2:0]  blk,     // cascade select
  output logic      [2:0]  ie,      // input edges: loc, pin, glb
  output logic      [2:0]  oe       // output edges: loc, pin, glb
);
  // idle: global edge every cycle, no request
  initial begin
    addr = 11'h000;
    rd_addr = 11'h000;
    din = 8'h00;
    we_loc = 1'b0;
    we_glb = 1'b0;
    pop = 1'b0;
    blk = 3'h0;
    ie = 3'h1;
    oe = 3'h1;
  end
  // request held across one edge, then data scrambled so stale never helps
  task wr(input logic [10:0] a, input logic [7:0] d, input logic g);
    @(posedge clk_sys);
    addr <= a;
    din <= d;
    we_glb <= g;
    we_loc <= ~g;
    @(posedge clk_sys);
    we_glb <= 1'b0;
    we_loc <= 1'b0;
    din <= ~d;
  endtask : wr
  // present read addresses, settle two edges
  task rd(input logic [10:0] a, input logic [10:0] ra);
    @(posedge clk_sys);
    addr <= a;
    rd_addr <= ra;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : rd
  // pick edge sources for both sides
  task en(input logic [2:0] i, input logic [2:0] o);
    @(posedge clk_sys);
    ie <= i;
    oe <= o;
  endtask : en
  task sel(input logic [2:0] b);
    @(posedge clk_sys);
    blk <= b;
  endtask : sel
  task popq;
    @(posedge clk_sys);
    pop <= 1'b1;
    @(posedge clk_sys);
    pop <= 1'b0;
  endtask : popq
endmodule : erb_user_model

// *** sim/test_erb_top.sv ***
// self-checking bench for the embedded ram block
`timescale 1ns/10ps
`include "erb_map.svh"
module test_erb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [10:0] ua;
  logic [10:0] ura;
  logic [7:0]  ud;
  logic        uwl;
  logic        uwg;
  logic        upop;
  logic [2:0]  ublk;
  logic [2:0]  uie;
  logic [2:0]  uoe;
  logic [7:0]  ram_dout;
  logic        fifo_full;
  logic        fifo_empty;
  logic [31:0] rq;
  logic        re;
  int          miscompares = 0;
  int          n_compared = 0;
  // ==========================================================================
  // clock, reset, instances
  always #25 clk_sys = ~clk_sys;
  erb_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ram_addr(ua),
    .ram_rd_addr(ura), .ram_din(ud), .we_local(uwl), .we_global(uwg),
    .fifo_pop(upop), .blk_sel(ublk), .in_en_glb(uie[0]),
    .in_en_pin(uie[1]), .in_en_loc(uie[2]), .out_en_glb(uoe[0]),
    .out_en_pin(uoe[1]), .out_en_loc(uoe[2]), .ram_dout(ram_dout),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty));
  erb_user_model u (.clk_sys(clk_sys), .addr(ua), .rd_addr(ura), .din(ud),
    .we_loc(uwl), .we_glb(uwg), .pop(upop), .blk(ublk), .ie(uie),
    .oe(uoe));
  // ==========================================================================
  // checking and apb helpers
  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // master holds the request until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      conclude();
    end else begin
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task rdc(input logic [11:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rq, x);
    chk(re, e);
  endtask : rdc
  // ==========================================================================
  // scenarios
  task t_reset;
    rdc(`ERB_OFS_CFG, 32'h0000_0000, 1'b0);
    apb(1'b1, `ERB_OFS_STAT, 32'hFFFF_FFFF);
    rdc(`ERB_OFS_STAT, 32'h0000_1000, 1'b0);
    apb(1'b1, 12'h010, 32'h0000_0001);
    chk(re, 1'b1);
    rdc(12'h010, 32'h0000_0000, 1'b1);
  endtask : t_reset
  // top word and word zero in every organisation
  task t_org;
    int o;
    logic [7:0] m;
    logic [10:0] top;
    for (o = 0; o < 4; o++) begin
      m = 8'hFF >> (8 - (8 >> o));
      top = (11'h100 << o) - 11'h001;
      apb(1'b1, `ERB_OFS_CFG, 32'(o) << 12);
      u.wr(top, 8'hFF, 1'b0);
      u.wr(11'h000, 8'h5A, 1'b0);
      u.rd(top, 11'h000);
      chk(ram_dout, m);
      u.rd(11'h000, 11'h000);
      chk(ram_dout, 8'h5A & m);
    end
  endtask : t_org
  task t_we;
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_0000);
    u.wr(11'h007, 8'h3C, 1'b1);
    u.rd(11'h007, 11'h000);
    chk(ram_dout, 8'h00);
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_0100);
    u.wr(11'h007, 8'h11, 1'b0);
    u.rd(11'h007, 11'h000);
    chk(ram_dout, 8'h00);
    u.wr(11'h007, 8'h3C, 1'b1);
    u.rd(11'h007, 11'h000);
    chk(ram_dout, 8'h3C);
  endtask : t_we
  // input edge from pin only, then a registered output on a local edge
  task t_clk;
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_0040);
    u.wr(11'h009, 8'h77, 1'b0);
    u.rd(11'h009, 11'h000);
    chk(ram_dout, 8'h00);
    u.en(3'b010, 3'b001);
    u.wr(11'h009, 8'h77, 1'b0);
    u.rd(11'h009, 11'h000);
    chk(ram_dout, 8'h77);
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_0420);
    u.en(3'b001, 3'b100);
    u.rd(11'h007, 11'h000);
    chk(ram_dout, 8'h3C);
    u.en(3'b001, 3'b000);
    u.rd(11'h009, 11'h000);
    chk(ram_dout, 8'h3C);
    u.en(3'b001, 3'b100);
    u.en(3'b001, 3'b000);
    u.rd(11'h009, 11'h000);
    chk(ram_dout, 8'h77);
    u.en(3'b001, 3'b001);
  endtask : t_clk
  // part of a 4x4 product table, multiplicand 3
  task t_lut;
    int b;
    apb(1'b1, `ERB_OFS_LDADR, 32'h0000_0030);
    for (b = 0; b < 16; b++) apb(1'b1, `ERB_OFS_LDDAT, 32'(3 * b));
    rdc(`ERB_OFS_LDADR, 32'h0000_0040, 1'b0);
    apb(1'b1, `ERB_OFS_CFG, 32'h0001_0000);
    u.rd(11'h035, 11'h000);
    chk(ram_dout, 8'h0F);
    u.wr(11'h035, 8'h00, 1'b0);
    u.rd(11'h03F, 11'h000);
    chk(ram_dout, 8'h2D);
    u.rd(11'h035, 11'h000);
    chk(ram_dout, 8'h0F);
    apb(1'b1, `ERB_OFS_LDADR, 32'h0000_0037);
    rdc(`ERB_OFS_LDDAT, 32'h0000_0015, 1'b0);
  endtask : t_lut
  task t_casc;
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_000A);
    u.sel(3'h1);
    u.wr(11'h014, 8'h99, 1'b0);
    u.rd(11'h014, 11'h000);
    chk(ram_dout, 8'h00);
    u.sel(3'h2);
    u.rd(11'h014, 11'h000);
    chk(ram_dout, 8'h00);
    u.wr(11'h014, 8'h99, 1'b0);
    u.rd(11'h014, 11'h000);
    chk(ram_dout, 8'h99);
    u.sel(3'h0);
  endtask : t_casc
  task t_fifo;
    int i;
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_C000);
    for (i = 1; i < 4; i++) u.wr(11'h000, 8'(8'h11 * i), 1'b0);
    rdc(`ERB_OFS_STAT, 32'h0000_0003, 1'b0);
    u.rd(11'h000, 11'h000);
    chk(ram_dout, 8'h11);
    u.popq();
    u.rd(11'h000, 11'h000);
    chk(ram_dout, 8'h22);
    u.popq();
    u.popq();
    rdc(`ERB_OFS_STAT, 32'h0000_1000, 1'b0);
    chk(fifo_empty, 1'b1);
  endtask : t_fifo
  // second port reads while the first points elsewhere
  task t_dp;
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_8000);
    u.wr(11'h004, 8'hC3, 1'b0);
    u.wr(11'h005, 8'h3C, 1'b0);
    u.rd(11'h005, 11'h004);
    chk(ram_dout, 8'hC3);
  endtask : t_dp
  // registered address alone takes live data; with data register, captured
  task t_regs;
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_0280);
    u.en(3'b100, 3'b001);
    u.wr(11'h020, 8'h5A, 1'b0);
    u.rd(11'h020, 11'h000);
    chk(ram_dout, 8'hA5);
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_0A80);
    u.wr(11'h021, 8'h5A, 1'b0);
    u.rd(11'h021, 11'h000);
    chk(ram_dout, 8'h5A);
    u.en(3'b001, 3'b001);
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_4000);
    u.wr(11'h021, 8'h00, 1'b0);
    u.rd(11'h021, 11'h000);
    chk(ram_dout, 8'h5A);
  endtask : t_regs
  // fill a 256-deep fifo, then one push too many
  task t_full;
    int i;
    apb(1'b1, `ERB_OFS_CFG, 32'h0000_C000);
    for (i = 0; i < 256; i++) u.wr(11'h000, 8'(i), 1'b0);
    u.wr(11'h000, 8'hFF, 1'b0);
    chk(fifo_full, 1'b1);
    rdc(`ERB_OFS_STAT, 32'h0000_2100, 1'b0);
    u.rd(11'h000, 11'h000);
    chk(ram_dout, 8'h00);
  endtask : t_full
  // ==========================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_org();
    t_we();
    t_clk();
    t_lut();
    t_casc();
    t_fifo();
    t_dp();
    t_regs();
    t_full();
    conclude();
  end
endmodule : test_erb_top
